// ===== dv/cmfi_host.sv
`timescale 1ns/1ps
`default_nettype none
module cmfi_host
    import cmfi_pkg::*;
(
    // Serial lines
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    // Chain symbol lines, index 0 faces the host
    output cmfi_sym_t [1:0] dc_rx,
    input wire cmfi_sym_t [1:0] dc_tx
);
    // ------------------------------------------------------------
    // Host end of the serial port, SCLK period 32 ns
    // ------------------------------------------------------------
    logic [3:0] last_cnt;
    int dup_cnt;
    int oe_bad;
    logic [47:0] sh [2];
    logic [47:0] rxf [2][4];
    int nsym [2];
    int nfr [2];

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        dc_rx = '0;
        last_cnt = 4'hf;
        dup_cnt = 0;
        oe_bad = 0;
    end

    // Clock stands low between frames, so select always falls with SCLK low
    task automatic xfer(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
        rx = 48'h0;
        cs_n = 1'b0;
        for (int k = 0; k < nbits; k++) begin
            #8 sdi = tx[47 - k];
            #8 sclk = 1'b1;
            // Taken as SCLK falls, before the device can react to that edge
            #16 rx = {rx[46:0], sdo};
            if (sdo_oe !== 1'b1) oe_bad++;
            sclk = 1'b0;
        end
        #8 cs_n = 1'b1;
        // Released data line has no pull, so show the inverse of the last bit
        sdi = ~sdi;
        if (nbits == 48) begin
            if (rx[15:12] === last_cnt) dup_cnt++;
            last_cnt = rx[15:12];
        end
    endtask

    // ------------------------------------------------------------
    // Chain end: one symbol per 500 ns, code settles before the toggle
    // ------------------------------------------------------------
    task automatic dc_sym(input int p, input logic [1:0] s);
        dc_rx[p].sym = s;
        #8 dc_rx[p].tgl = ~dc_rx[p].tgl;
        #492;
    endtask

    task automatic dc_send(input int p, input logic [47:0] f, input int nbits);
        dc_sym(p, SYM_START);
        for (int k = 0; k < nbits; k++) begin
            dc_sym(p, {1'b1, f[47 - k]});
        end
        dc_sym(p, SYM_END);
    endtask

    task automatic dc_clear();
        nsym = '{0, 0};
        nfr = '{0, 0};
    endtask

    // Select edges only matter to a sleeping chain node
    task automatic cs_toggle();
        cs_n = ~cs_n;
    endtask

    // A frame is kept as its end symbol arrives
    for (genvar p = 0; p < 2; p++) begin : g_mon
        always @(dc_tx[p].tgl) begin
            nsym[p]++;
            if (dc_tx[p].sym[1]) begin
                sh[p] = {sh[p][46:0], dc_tx[p].sym[0]};
            end else if (dc_tx[p].sym == SYM_END && nfr[p] < 4) begin
                rxf[p][nfr[p]] = sh[p];
                nfr[p]++;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cmfi_pkg::*;
;
    // ------------------------------------------------------------
    // Clock, reset and wiring
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic err_clr = 1'b0;
    logic sleep = 1'b0;
    logic wake_mask = 1'b0;
    logic ser_sel = 1'b1;
    logic [5:0] cluster_id = 6'h00;
    wire logic sclk, cs_n, sdi, sdo, sdo_oe, reg_we, err_flag, wake_req;
    wire logic [6:0] reg_addr;
    wire logic [15:0] reg_wdata, reg_rdata;
    wire logic [7:0] err_count;
    wire logic [5:0] dc_rx, dc_tx;
    logic [15:0] mem [128];
    cmfi_frame_t rsp;
    logic [3:0] exp_cnt = 4'h0;
    int failures = 0;
    int compares = 0;
    int wakes = 0;

    always #2 core_clk = ~core_clk;

    cmfi_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .dc_rx(dc_rx), .dc_tx(dc_tx));

    cmfi_frame_if dut (.CORE_CLK(core_clk), .RST_N(rst_n), .SERIAL_SEL(ser_sel),
        .CLUSTER_ID(cluster_id), .SCLK(sclk), .CHIP_SELECT_N(cs_n), .SDI(sdi), .SDO(sdo),
        .SDO_OE(sdo_oe), .DC_RX(dc_rx), .DC_TX(dc_tx), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RDATA(reg_rdata),
        .COMM_ERR_CLR(err_clr), .COMM_ERR_FLAG(err_flag), .COMM_ERR_COUNT(err_count),
        .SLEEP(sleep), .WAKE_MASK(wake_mask), .WAKE_REQ(wake_req));

    // Register file stand-in, read data follows the address
    initial for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
    always @(posedge core_clk) if (reg_we) mem[reg_addr] <= reg_wdata;
    assign reg_rdata = mem[reg_addr];

    // Wake pulses last one cycle, so every falling edge looks
    always @(negedge core_clk) if (wake_req === 1'b1) wakes++;

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] crc_of(input logic [39:0] m);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 39; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h2f : 8'h00);
        return c;
    endfunction

    function automatic cmfi_frame_t mk(input logic [1:0] op, input logic [6:0] a,
        input logic [15:0] d, input logic ms, input logic [5:0] c);
        cmfi_frame_t f;
        f = '0;
        f.cmd = op;
        f.addr = a;
        f.data = d;
        f.ms = ms;
        f.cluster_id = c;
        f.crc = crc_of(f[47:8]);
        return f;
    endfunction

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One exchange; the counter of every full response is tracked
    task automatic ex(input cmfi_frame_t f, input int n);
        #3;
        host.xfer(f, n, rsp);
        if (n == 48) check(48'(rsp.cnt), 48'(exp_cnt));
        exp_cnt++;
        repeat (40) @(negedge core_clk);
        check(48'(sdo_oe), 48'h0);
    endtask

    task automatic chk_zero();
        cmfi_frame_t z;
        z = '0;
        z.cnt = rsp.cnt;
        z.crc = crc_of(z[47:8]);
        check(rsp, z);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_first();
        ex(mk(CMD_NOP, 7'h00, 16'h0000, 1'b0, 6'h00), 48);
        chk_zero();
        $display("test first_response done");
    endtask

    task automatic t_write();
        ex(mk(CMD_WRITE, 7'h05, 16'h1234, 1'b0, 6'h00), 48);
        check(48'(rsp.cmd), 48'(CMD_NOP));
        check(48'(mem[5]), 48'h1234);
        ex(mk(CMD_NOP, 7'h00, 16'h0000, 1'b0, 6'h00), 48);
        check({25'h0, rsp.data, rsp.addr}, {25'h0, 16'h1234, 7'h05});
        check(48'(rsp.crc), 48'(crc_of(rsp[47:8])));
        $display("test write_readback done");
    endtask

    task automatic t_refused();
        ex(mk(CMD_GLOBAL, 7'h06, 16'h5555, 1'b0, 6'h00), 48);
        check(48'(mem[6]), 48'h0);
        ex(mk(CMD_NOP, 7'h00, 16'h0000, 1'b0, 6'h00), 48);
        chk_zero();
        ex(mk(CMD_WRITE, 7'h05, 16'hbeef, 1'b1, 6'h00), 48);
        check(48'(mem[5]), 48'h1234);
        ex(mk(CMD_NOP, 7'h00, 16'h0000, 1'b0, 6'h00), 48);
        chk_zero();
        ex(mk(CMD_READ, 7'h05, 16'h0000, 1'b0, 6'h03), 48);
        ex(mk(CMD_NOP, 7'h00, 16'h0000, 1'b0, 6'h00), 48);
        chk_zero();
        $display("test refused_requests done");
    endtask

    task automatic t_fault();
        cmfi_frame_t f;
        f = mk(CMD_READ, 7'h05, 16'h0000, 1'b0, 6'h00);
        f.crc = ~f.crc;
        ex(f, 48);
        check({39'h0, err_flag, err_count}, {39'h0, 1'b1, 8'h01});
        ex(mk(CMD_NOP, 7'h00, 16'h0000, 1'b0, 6'h00), 48);
        chk_zero();
        ex(mk(CMD_NOP, 7'h00, 16'h0000, 1'b0, 6'h00), 47);
        check(48'(err_count), 48'h02);
        err_clr = 1'b1;
        @(negedge core_clk);
        err_clr = 1'b0;
        @(negedge core_clk);
        check({39'h0, err_flag, err_count}, {39'h0, 1'b0, 8'h02});
        ex(mk(CMD_NOP, 7'h00, 16'h0000, 1'b0, 6'h00), 48);
        check(48'(host.dup_cnt), 48'h0);
        check(48'(host.oe_bad), 48'h0);
        $display("test comm_faults done");
    endtask

    // The mode pin is only taken in reset, so chain mode needs a fresh one
    task automatic t_chain();
        cmfi_frame_t f;
        cmfi_frame_t e;
        rst_n = 1'b0;
        ser_sel = 1'b0;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge core_clk);
        host.dc_clear();
        host.dc_send(0, mk(CMD_WRITE, 7'h06, 16'h00a5, 1'b0, 6'h00), 48);
        check(48'(mem[6]), 48'h00a5);
        check(48'(host.nsym[0]), 48'h0);
        host.dc_send(0, mk(CMD_READ, 7'h05, 16'h0002, 1'b0, 6'h00), 48);
        repeat (12700) @(negedge core_clk);
        check(48'(host.nsym[0]), 48'h64);
        e = mk(CMD_READ, 7'h05, 16'h1234, 1'b1, 6'h00);
        e.cnt = 4'h1;
        e.crc = crc_of(e[47:8]);
        check(host.rxf[0][0], e);
        e = mk(CMD_READ, 7'h06, 16'h00a5, 1'b1, 6'h00);
        e.cnt = 4'h2;
        e.crc = crc_of(e[47:8]);
        check(host.rxf[0][1], e);
        check(48'(host.nsym[1]), 48'h0);
        f = mk(CMD_READ, 7'h05, 16'h0001, 1'b0, 6'h00);
        f.crc = ~f.crc;
        host.dc_send(0, f, 48);
        host.dc_send(0, mk(CMD_NOP, 7'h00, 16'h0000, 1'b0, 6'h00), 47);
        check({39'h0, err_flag, err_count}, {39'h0, 1'b1, 8'h02});
        check(48'(host.nsym[0]), 48'h64);
        cluster_id = 6'h01;
        host.dc_clear();
        f = mk(CMD_READ, 7'h05, 16'h0001, 1'b0, 6'h02);
        host.dc_send(0, f, 48);
        check(48'(host.nsym[1]), 48'h32);
        check(host.rxf[1][0], f);
        check(48'(host.nsym[0]), 48'h0);
        sleep = 1'b1;
        repeat (2) begin
            host.cs_toggle();
            repeat (10) @(negedge core_clk);
        end
        check(48'(wakes), 48'h2);
        wake_mask = 1'b1;
        repeat (2) begin
            host.cs_toggle();
            repeat (10) @(negedge core_clk);
        end
        check(48'(wakes), 48'h2);
        $display("test chain_mode done");
    endtask

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge core_clk);
        t_first();
        t_write();
        t_refused();
        t_fault();
        t_chain();
        end_sim();
    end

    // Tests need about 200 us; a hang is cut well after that
    initial begin
        #300000;
        failures++;
        end_sim();
    end
endmodule
`default_nettype wire

// ===== src/cmfi_frame_if.sv
`timescale 1ns/1ps
`default_nettype none
module cmfi_frame_if
    import cmfi_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Mode and identity
    input wire logic SERIAL_SEL,
    input wire logic [5:0] CLUSTER_ID,
    // Serial port
    input wire logic SCLK,
    input wire logic CHIP_SELECT_N,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE,
    // Daisy-chain symbol ports, index 0 faces the host
    input wire cmfi_sym_t [1:0] DC_RX,
    output cmfi_sym_t [1:0] DC_TX,
    // Register file
    output logic [6:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    output logic REG_WE,
    input wire logic [15:0] REG_RDATA,
    // Faults and wake-up
    input wire logic COMM_ERR_CLR,
    output logic COMM_ERR_FLAG,
    output logic [7:0] COMM_ERR_COUNT,
    input wire logic SLEEP,
    input wire logic WAKE_MASK,
    output logic WAKE_REQ
);

    // ------------------------------------------------------------
    // Serial shift logic on the link clock
    // ------------------------------------------------------------
    cmfi_frame_t resp_r;
    logic [5:0] bit_cnt_r;
    logic [47:0] rx_sh_r;
    logic sdo_r;
    wire [5:0] tx_idx = (bit_cnt_r < FRAME_BITS) ? 6'(6'h2f - bit_cnt_r) : 6'h00;

    always_ff @(negedge SCLK or posedge CHIP_SELECT_N) begin
        if (CHIP_SELECT_N) begin
            bit_cnt_r <= 6'h00;
        end else if (bit_cnt_r != LEN_MAX) begin
            bit_cnt_r <= 6'(bit_cnt_r + 6'h01);
        end
    end

    always_ff @(negedge SCLK) begin
        rx_sh_r <= {rx_sh_r[46:0], SDI};
    end

    // Response word is only rewritten while select is high, so it is static here
    always_ff @(posedge SCLK) begin
        sdo_r <= resp_r[tx_idx];
    end

    assign SDO = (bit_cnt_r == 6'h00) ? resp_r[47] : sdo_r;
    assign SDO_OE = !CHIP_SELECT_N;

    // ------------------------------------------------------------
    // Synchronisers into the core clock
    // ------------------------------------------------------------
    logic [8:0] sy1_r, sy2_r;
    logic csb_d_r, sclk_d_r;
    logic [1:0] tgl_d_r;
    wire csb_s = sy2_r[8];
    wire sclk_s = sy2_r[7];
    wire mode_s = sy2_r[6];
    cmfi_sym_t [1:0] rx;
    assign rx = sy2_r[5:0];

    always_ff @(posedge CORE_CLK) begin
        sy1_r <= {CHIP_SELECT_N, SCLK, SERIAL_SEL, DC_RX};
        sy2_r <= sy1_r;
        csb_d_r <= csb_s;
        sclk_d_r <= sclk_s;
        tgl_d_r <= {rx[1].tgl, rx[0].tgl};
    end

    wire csb_rise = csb_s & !csb_d_r;
    wire csb_fall = !csb_s & csb_d_r;
    wire sclk_fall = !sclk_s & sclk_d_r;

    // ------------------------------------------------------------
    // Serial frame length and clock phase checks
    // ------------------------------------------------------------
    logic serial_mode_r, phase_bad_r;
    logic [5:0] len_r;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            serial_mode_r <= mode_s;
            phase_bad_r <= 1'b0;
            len_r <= 6'h00;
        end else if (csb_fall) begin
            phase_bad_r <= sclk_s;
            len_r <= 6'h00;
        end else if (!csb_s && sclk_fall && len_r != LEN_MAX) begin
            len_r <= 6'(len_r + 6'h01);
        end
    end

    // ------------------------------------------------------------
    // Daisy-chain receivers
    // ------------------------------------------------------------
    logic [1:0] rx_ev, dc_done, dc_bad;
    logic [5:0] dc_cnt_r [2];
    logic [47:0] dc_sh_r [2];

    for (genvar p = 0; p < 2; p++) begin : g_rx
        assign rx_ev[p] = rx[p].tgl ^ tgl_d_r[p];
        wire is_bit = rx[p].sym[1];
        wire is_end = rx[p].sym == SYM_END;
        assign dc_done[p] = rx_ev[p] & is_end & (dc_cnt_r[p] == FRAME_BITS);
        assign dc_bad[p] = rx_ev[p] & is_end & (dc_cnt_r[p] != FRAME_BITS);
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                dc_cnt_r[p] <= LEN_MAX;
                dc_sh_r[p] <= 48'h0;
            end else if (rx_ev[p] && rx[p].sym == SYM_START) begin
                dc_cnt_r[p] <= 6'h00;
            end else if (rx_ev[p] && is_bit && dc_cnt_r[p] != LEN_MAX) begin
                dc_sh_r[p] <= {dc_sh_r[p][46:0], rx[p].sym[0]};
                dc_cnt_r[p] <= 6'(dc_cnt_r[p] + 6'h01);
            end
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    cmfi_state_t st_r;
    cmfi_frame_t cmd_r;
    logic bad_r, daisy_r, port_r, zero_r;
    logic [6:0] addr_r;
    logic [5:0] burst_r, seq_idx_r;
    logic [7:0] gap_r;
    logic [3:0] msg_cnt_r;

    wire crc_ok = cmfi_crc8(cmd_r[47:8]) == cmd_r.crc;
    wire bad = bad_r | !crc_ok;
    wire cid_hit = cmd_r.cluster_id == CLUSTER_ID;
    wire for_me = cid_hit & (CLUSTER_ID != CID_INIT | !port_r);
    wire is_glob = cmd_r.cmd == CMD_GLOBAL;
    wire usable = !bad & !cmd_r.ms;
    wire exec_wr = usable & ((for_me & cmd_r.cmd == CMD_WRITE) | (daisy_r & is_glob));
    wire dc_read = usable & for_me & cmd_r.cmd == CMD_READ;
    wire ser_zero = !usable | !for_me | is_glob;
    wire dc_take = !serial_mode_r & |dc_done;
    wire ser_take = serial_mode_r & csb_rise;
    wire fwd_en = !serial_mode_r & CLUSTER_ID != CID_INIT;
    wire fwd_busy = fwd_en & rx_ev[!port_r];
    wire seq_fire = st_r == ST_SEND && gap_r == 8'h00 && seq_idx_r != SEQ_DONE && !fwd_busy;
    wire seq_end = st_r == ST_SEND && gap_r == 8'h00 && seq_idx_r == SEQ_DONE;
    wire [1:0] seq_sym = (seq_idx_r == 6'h00) ? SYM_START :
                         (seq_idx_r == SEQ_LAST) ? SYM_END :
                         {1'b1, resp_r[6'(FRAME_BITS - seq_idx_r)]};

    assign REG_ADDR = addr_r;
    assign REG_WDATA = cmd_r.data;
    assign REG_WE = st_r == ST_EXEC && exec_wr;

    // Response assembly from current register contents
    cmfi_frame_t rb;
    always_comb begin
        rb = '0;
        if (!zero_r) begin
            rb.data = (cmd_r.cmd == CMD_NOP) ? 16'h0000 : REG_RDATA;
            rb.ms = 1'b1;
            rb.addr = addr_r;
            rb.cluster_id = CLUSTER_ID;
            rb.cmd = cmd_r.cmd;
        end
        rb.cnt = msg_cnt_r;
        rb.crc = cmfi_crc8(rb[47:8]);
    end

    // ------------------------------------------------------------
    // Command and response sequencing
    // ------------------------------------------------------------
    // Frames arriving while a command is in flight are dropped
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            st_r <= ST_BUILD;
            zero_r <= 1'b1;
            daisy_r <= 1'b0;
            cmd_r <= '0;
            bad_r <= 1'b0;
            port_r <= 1'b0;
            addr_r <= 7'h00;
            burst_r <= 6'h00;
            resp_r <= '0;
            msg_cnt_r <= 4'h0;
            seq_idx_r <= 6'h00;
            gap_r <= 8'h00;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                    if (ser_take) begin
                        cmd_r <= rx_sh_r;
                        addr_r <= rx_sh_r[30:24];
                        bad_r <= len_r != FRAME_BITS || phase_bad_r;
                        daisy_r <= 1'b0;
                        port_r <= 1'b0;
                        st_r <= ST_EXEC;
                    end else if (dc_take) begin
                        cmd_r <= dc_done[0] ? dc_sh_r[0] : dc_sh_r[1];
                        addr_r <= dc_done[0] ? dc_sh_r[0][30:24] : dc_sh_r[1][30:24];
                        bad_r <= 1'b0;
                        daisy_r <= 1'b1;
                        port_r <= !dc_done[0];
                        st_r <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    zero_r <= ser_zero;
                    burst_r <= (cmd_r.data[5:0] == 6'h00) ? 6'h00 : 6'(cmd_r.data[5:0] - 6'h01);
                    st_r <= (!daisy_r || dc_read) ? ST_BUILD : ST_IDLE;
                end
                ST_BUILD: begin
                    resp_r <= rb;
                    msg_cnt_r <= 4'(msg_cnt_r + 4'h1);
                    seq_idx_r <= 6'h00;
                    gap_r <= 8'h00;
                    st_r <= daisy_r ? ST_SEND : ST_IDLE;
                end
                ST_SEND: begin
                    if (seq_fire) begin
                        seq_idx_r <= 6'(seq_idx_r + 6'h01);
                        gap_r <= 8'(SYM_CYC - 8'h01);
                    end else if (gap_r != 8'h00) begin
                        gap_r <= 8'(gap_r - 8'h01);
                    end else if (seq_end && burst_r != 6'h00) begin
                        burst_r <= 6'(burst_r - 6'h01);
                        addr_r <= 7'(addr_r + 7'h01);
                        st_r <= ST_BUILD;
                    end else if (seq_end) begin
                        st_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Chain transmitters: forwarding takes the port ahead of own answers
    // ------------------------------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_tx
        always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
                DC_TX[p] <= '0;
            end else if (fwd_en && rx_ev[1-p]) begin
                DC_TX[p] <= {rx[1-p].sym, !DC_TX[p].tgl};
            end else if (seq_fire && port_r == 1'(p)) begin
                DC_TX[p] <= {seq_sym, !DC_TX[p].tgl};
            end
        end
    end

    // ------------------------------------------------------------
    // Fault flag, error counter and wake-up
    // ------------------------------------------------------------
    wire err_ev = (st_r == ST_EXEC && bad) || (!serial_mode_r && |dc_bad);

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            COMM_ERR_FLAG <= 1'b0;
            COMM_ERR_COUNT <= 8'h00;
            WAKE_REQ <= 1'b0;
        end else begin
            COMM_ERR_FLAG <= err_ev | (COMM_ERR_FLAG & !COMM_ERR_CLR);
            if (err_ev && COMM_ERR_COUNT != ERR_CNT_MAX) begin
                COMM_ERR_COUNT <= 8'(COMM_ERR_COUNT + 8'h01);
            end
            WAKE_REQ <= !serial_mode_r & SLEEP & !WAKE_MASK & (csb_s ^ csb_d_r);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    err_flag_a:
        assert property (st_r == ST_EXEC && bad |=> COMM_ERR_FLAG && st_r != ST_SEND)
        else $error("fault flag not set on corrupt frame");
    cnt_step_a:
        assert property (st_r == ST_BUILD |=> resp_r.cnt == $past(msg_cnt_r)
                         && msg_cnt_r == 4'($past(msg_cnt_r) + 4'h1))
        else $error("message counter not advanced");
    resp_crc_a:
        assert property ($rose(st_r == ST_IDLE) && !daisy_r |-> resp_r.crc == cmfi_crc8(resp_r[47:8]))
        else $error("response crc wrong");
    ms_block_a:
        assert property (st_r == ST_EXEC && cmd_r.ms |-> !REG_WE ##1 (daisy_r || zero_r))
        else $error("master bit command acted on");
    zero_resp_a:
        assert property (st_r == ST_EXEC && !daisy_r && !for_me |=> ##1
                         resp_r.data == 16'h0000 && resp_r.addr == 7'h00 && !resp_r.ms)
        else $error("invalid request not answered with zero frame");
    dc_noresp_a:
        assert property (st_r == ST_EXEC && daisy_r && cmd_r.cmd != CMD_READ |=> st_r == ST_IDLE)
        else $error("chain non-read answered");
    fwd_port_a:
        assert property (fwd_en && rx_ev[0] |=> DC_TX[1].tgl != $past(DC_TX[1].tgl)
                         && DC_TX[1].sym == $past(rx[0].sym))
        else $error("chain frame not forwarded");
    wake_gate_a:
        assert property (WAKE_REQ |-> $past(SLEEP) && !$past(WAKE_MASK) && !$past(serial_mode_r))
        else $error("wake raised while masked");
    burst_len_a:
        assert property (seq_end && burst_r != 6'h00 |=> st_r == ST_BUILD ##1 st_r == ST_SEND)
        else $error("burst response missing");

endmodule
`default_nettype wire

// ===== src/cmfi_pkg.sv
package cmfi_pkg;

    // ------------------------------------------------------------
    // Frame layout and link symbols
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] data;
        logic ms;
        logic [6:0] addr;
        logic [1:0] rsv_a;
        logic [5:0] cluster_id;
        logic [3:0] cnt;
        logic [1:0] rsv_b;
        logic [1:0] cmd;
        logic [7:0] crc;
    } cmfi_frame_t;

    typedef struct packed {
        logic [1:0] sym;
        logic tgl;
    } cmfi_sym_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_EXEC = 4'h2,
        ST_BUILD = 4'h4,
        ST_SEND = 4'h8
    } cmfi_state_t;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam logic [5:0] FRAME_BITS = 6'h30;
    localparam logic [5:0] LEN_MAX = 6'h3f;
    localparam logic [5:0] SEQ_LAST = 6'h31;
    localparam logic [5:0] SEQ_DONE = 6'h32;
    localparam logic [1:0] CMD_NOP = 2'h0;
    localparam logic [1:0] CMD_READ = 2'h1;
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_GLOBAL = 2'h3;
    localparam logic [7:0] CRC_POLY = 8'h2f;
    localparam logic [7:0] CRC_SEED = 8'hff;
    localparam logic [5:0] CID_INIT = 6'h00;
    localparam logic [1:0] SYM_START = 2'h0;
    localparam logic [1:0] SYM_END = 2'h1;
    localparam logic [1:0] SYM_ZERO = 2'h2;
    localparam logic [1:0] SYM_ONE = 2'h3;
    localparam logic [7:0] ERR_CNT_MAX = 8'hff;
    localparam int CLK_PS = 4000;
    localparam int SYM_NS = 500;
    localparam logic [7:0] SYM_CYC = 8'(SYM_NS * 1000 / CLK_PS);

    // Direct form over the 40 header bits, seed preloaded
    function automatic logic [7:0] cmfi_crc8(input logic [39:0] msg);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 39; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ msg[i]) ? CRC_POLY : 8'h00);
        end
        return c;
    endfunction

endpackage
